// File: common/rcf_pkg.sv
package rcf_pkg;

  // bus and register geometry
  localparam int RCF_AW = 16;
  localparam int RCF_DW = 8;
  localparam int NREG = 27;

  // register indices
  localparam int IX_CAUSE = 0;
  localparam int IX_LVCTL = 1;
  localparam int IX_LVLVL = 2;
  localparam int IX_OSSEL = 3;
  localparam int IX_OSSTAT = 4;
  localparam int IX_MEMSZ = 5;
  localparam int IX_XRAMSZ = 6;
  localparam int IX_WDTEN = 7;
  localparam int IX_U0MODE = 8;
  localparam int IX_U0RX = 9;
  localparam int IX_U6MODE = 10;
  localparam int IX_U6RX = 11;
  localparam int IX_U6CTL = 12;
  localparam int IX_CLKCTL = 13;
  localparam int IX_PORTIND = 14;
  localparam int IX_IRQF = 15;
  localparam int IX_MASK = 19;
  localparam int IX_PRIO = 23;

  // register byte addresses
  localparam logic [15:0] REG_ADDR [NREG] = '{
    16'hFFAC, 16'hFFBE, 16'hFFBF, 16'hFFA4, 16'hFFA3, 16'hFFF0, 16'hFFF4, 16'hFF99, 16'hFF70,
    16'hFF71, 16'hFF50, 16'hFF52, 16'hFF57, 16'hFFA0, 16'hFF0D, 16'hFFE0, 16'hFFE1, 16'hFFE2,
    16'hFFE3, 16'hFFE4, 16'hFFE5, 16'hFFE6, 16'hFFE7, 16'hFFE8, 16'hFFE9, 16'hFFEA, 16'hFFEB};

  // reset values
  localparam logic [7:0] REG_RST [NREG] = '{
    8'h00, 8'h00, 8'h00, 8'h05, 8'h00, 8'hCF, 8'h0C, 8'h1A, 8'h01,
    8'hFF, 8'h01, 8'hFF, 8'h16, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

  // writable bits
  localparam logic [7:0] REG_MASK [NREG] = '{
    8'h11, 8'h87, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h01, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

  // registers software may only read
  localparam logic [NREG-1:0] REG_RO = (NREG'(1) << IX_CAUSE) | (NREG'(1) << IX_OSSTAT) |
                                       (NREG'(1) << IX_U0RX) | (NREG'(1) << IX_U6RX);
  // registers kept through a reset caused only by the low-voltage detector
  localparam logic [NREG-1:0] REG_LVH = (NREG'(1) << IX_LVCTL) | (NREG'(1) << IX_LVLVL);

  // field layout and special values
  localparam int CAUSE_WDT_BIT = 4;
  localparam int CAUSE_LV_BIT = 0;
  localparam logic [7:0] WATCHDOG_ENABLE_REGISTER_RST_ALT = 8'h9A;
  localparam logic [7:0] OSSTAT_DONE = 8'h1F;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam int OSSEL_W = 3;
  localparam int CLK_MAIN_BIT = 0;
  localparam int CLK_SUB_BIT = 1;
  localparam int CLK_EXTM_BIT = 2;
  localparam int CLK_EXTS_BIT = 3;
  localparam int PORTIND_LVL_BIT = 0;
  localparam logic [15:0] VEC_LO_ADDR = 16'h0000;
  localparam logic [15:0] VEC_HI_ADDR = 16'h0001;

  // source vector positions
  localparam int SRC_PIN = 0;
  localparam int SRC_POC = 1;
  localparam int SRC_LVI = 2;
  localparam int SRC_WDT = 3;
  localparam int NSRC = 4;

  // reset sequence states, gray along the path
  typedef enum logic [2:0] {
    ST_HOLD = 3'b000,
    ST_SETTLE = 3'b001,
    ST_VEC_LO = 3'b011,
    ST_VEC_HI = 3'b010,
    ST_LOAD = 3'b110,
    ST_RUN = 3'b111
  } rcf_state_e;

endpackage : rcf_pkg

// File: design/rcf_src_merge.sv
`timescale 1ns/10ps
`default_nettype none

module rcf_src_merge
  import rcf_pkg::*;
#(
  parameter int N = 4
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [N-1:0] src_in,
  input wire logic seen_clr,
  output logic src_any,
  output logic [N-1:0] seen
);
  import rcf_pkg::*;

  logic [N-1:0] src_q;
  logic [N-1:0] next_src_q;
  logic [N-1:0] next_seen;

  ////////////////////////////////////////////////////////////////////////////
  // one registered stage per source, sticky seen flags per episode
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_src
      always_comb begin
        next_src_q[g] = src_in[g];
        next_seen[g] = seen_clr ? src_in[g] : (seen[g] | src_in[g]); // flags ready with the stage, not after it
      end
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          src_q[g] <= 1'b0;
          seen[g] <= (g == SRC_POC); // power-up counts as a power-on reset
        end else begin
          src_q[g] <= next_src_q[g];
          seen[g] <= next_seen[g];
        end
      end
    end
  endgenerate

  // one internal reset from all sources
  assign src_any = |src_q;

endmodule : rcf_src_merge

`default_nettype wire

// File: design/rcf_reset_ctrl.sv
// Notes on behaviour
// - reset indicator pin drives low during any reset; other pins float.
// - watchdog reset also resets the watchdog, then releases by itself.
// - cpu clock gated and high-speed oscillators stopped while in reset.
// - crystals stop, external clocks ignored, their pins become ports.
// - program counter loaded from the two-byte vector at addresses 0 and 1.
// - during reset and settle only the program counter is undefined.
// - reset in standby keeps ram and general registers.
// - settle select resets to 05H, settle status to 00H.
// - memory size switches reset to fixed values; software adjusts them.
// - watchdog enable reset value chosen by option byte.
// - uart mode registers reset to 01H, receive buffers to FFH.
// - second uart control register resets to 16H.
// - interrupt masks and priorities reset to FFH, requests to 00H.
// - cause register: watchdog flag bit 4, low-voltage flag bit 0, rest zero.
// - pin and power-on clear both flags; watchdog and low-voltage set their own.
// - any read of the cause register while running clears it.
// - low-voltage registers cleared except by a low-voltage reset.
// - after release execution starts on the internal high-speed clock.
`timescale 1ns/10ps
`default_nettype none

module rcf_reset_ctrl
  import rcf_pkg::*;
#(
  parameter int HOLD_MIN = 4,
  parameter int SETTLE_UNIT = 8
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ext_rst_n,
  input wire logic poc_det,
  input wire logic lvi_det,
  input wire logic wdt_ovf,
  input wire logic standby,
  input wire logic opt_wdt_alt,
  input wire logic [RCF_AW-1:0] addr,
  input wire logic [RCF_DW-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [RCF_DW-1:0] rdata,
  output logic [15:0] vec_addr,
  output logic vec_rd,
  input wire logic [7:0] vec_data,
  output logic [15:0] pc,
  output logic pc_load,
  output logic cpu_clk_en,
  output logic hs_osc_en,
  output logic main_osc_en,
  output logic sub_osc_en,
  output logic ext_main_clk_en,
  output logic ext_sub_clk_en,
  output logic clk_pin_port_mode,
  output logic port_hiz,
  output logic reset_ind_o,
  output logic reset_ind_oe,
  output logic periph_rst,
  output logic wdt_rst,
  output logic lvd_rst,
  output logic ram_retain
);
  import rcf_pkg::*;

  rcf_state_e state;
  rcf_state_e next_state;
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic [7:0] pc_lo;
  logic [7:0] next_pc_lo;
  logic [7:0] rf [NREG];
  logic [7:0] next_rf [NREG];
  logic [NSRC-1:0] src_in;
  logic [NSRC-1:0] seen;
  logic src_any;
  logic seen_clr;
  logic lvi_only;
  logic clr_flags;
  logic cause_rd;
  logic settle_done;
  logic [15:0] settle_len;
  logic [RCF_DW-1:0] next_rdata;
  logic [15:0] next_vec_addr;
  logic next_vec_rd;
  logic [15:0] next_pc;
  logic next_pc_load;
  logic next_cpu_clk_en;
  logic next_hs_osc_en;
  logic next_main_osc_en;
  logic next_sub_osc_en;
  logic next_ext_main_clk_en;
  logic next_ext_sub_clk_en;
  logic next_clk_pin_port_mode;
  logic next_port_hiz;
  logic next_reset_ind_o;
  logic next_periph_rst;
  logic next_wdt_rst;
  logic next_lvd_rst;
  logic next_ram_retain;
  logic in_rst_next;

  ////////////////////////////////////////////////////////////////////////////
  // source merging

  // pin is active low, the rest active high
  assign src_in[SRC_PIN] = ~ext_rst_n;
  assign src_in[SRC_POC] = poc_det;
  assign src_in[SRC_LVI] = lvi_det;
  assign src_in[SRC_WDT] = wdt_ovf;
  assign seen_clr = (state == ST_LOAD);

  rcf_src_merge #(
    .N(NSRC)
  ) u_merge (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .src_in(src_in),
    .seen_clr(seen_clr),
    .src_any(src_any),
    .seen(seen)
  );

  // episode classification
  assign lvi_only = seen[SRC_LVI] & ~seen[SRC_PIN] & ~seen[SRC_POC] & ~seen[SRC_WDT];
  assign clr_flags = seen[SRC_PIN] | seen[SRC_POC];
  assign cause_rd = rd && (addr == REG_ADDR[IX_CAUSE]) && (state == ST_RUN);
  assign settle_len = 16'(SETTLE_UNIT) << rf[IX_OSSEL][OSSEL_W-1:0];
  assign settle_done = (state == ST_SETTLE) && (cnt >= settle_len - 16'h0001);

  ////////////////////////////////////////////////////////////////////////////
  // reset sequence

  // hold, settle wait, vector fetch, run
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_pc_lo = pc_lo;
    if (src_any) begin
      next_state = ST_HOLD;
      next_cnt = 16'h0000;
    end else begin
      unique case (state)
        ST_HOLD: begin
          // a watchdog pulse still gets a minimum hold, then releases alone
          if (cnt >= 16'(HOLD_MIN - 1)) begin
            next_state = ST_SETTLE;
            next_cnt = 16'h0000;
          end else begin
            next_cnt = cnt + 16'h0001;
          end
        end
        ST_SETTLE: begin
          if (settle_done) begin
            next_state = ST_VEC_LO;
            next_cnt = 16'h0000;
          end else begin
            next_cnt = cnt + 16'h0001;
          end
        end
        ST_VEC_LO: begin
          next_state = ST_VEC_HI;
        end
        ST_VEC_HI: begin
          next_pc_lo = vec_data; // low byte of the vector
          next_state = ST_LOAD;
        end
        ST_LOAD: begin
          next_state = ST_RUN;
        end
        ST_RUN: begin
          next_state = ST_RUN;
        end
        default: begin
          next_state = ST_HOLD;
        end
      endcase
    end
  end

  // sequence registers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state <= ST_HOLD;
      cnt <= 16'h0000;
      pc_lo <= BYTE_ZERO;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      pc_lo <= next_pc_lo;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file

  // reset values, software writes, cause flags, settle status
  always_comb begin
    next_rf = rf;
    for (int i = 0; i < NREG; i++) begin
      if (state == ST_HOLD) begin
        // low-voltage registers survive a reset that only the detector caused
        if (!(REG_LVH[i] && lvi_only)) begin
          // fixed reset images for switches, uarts and interrupt flags
          next_rf[i] = REG_RST[i];
        end
        if (i == IX_WDTEN && opt_wdt_alt) begin
          next_rf[i] = WATCHDOG_ENABLE_REGISTER_RST_ALT;
        end
      end else if (wr && state == ST_RUN && addr == REG_ADDR[i] && !REG_RO[i]) begin
        // writes only while running, so state holds through settle
        next_rf[i] = wdata & REG_MASK[i];
      end
    end
    // cause flags: read clears, pin or power-on clears, set wins last
    next_rf[IX_CAUSE] = rf[IX_CAUSE];
    if (cause_rd) begin
      next_rf[IX_CAUSE] = BYTE_ZERO;
    end
    if (state == ST_HOLD) begin
      if (clr_flags) begin
        next_rf[IX_CAUSE] = BYTE_ZERO;
      end
      if (seen[SRC_WDT]) begin
        next_rf[IX_CAUSE][CAUSE_WDT_BIT] = 1'b1;
      end
      if (seen[SRC_LVI]) begin
        next_rf[IX_CAUSE][CAUSE_LV_BIT] = 1'b1;
      end
    end
    // settle status shows the wait finishing
    if (state == ST_HOLD) begin
      next_rf[IX_OSSTAT] = BYTE_ZERO;
    end else if (settle_done) begin
      next_rf[IX_OSSTAT] = OSSTAT_DONE;
    end
  end

  // register storage
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NREG; i++) begin
        rf[i] <= REG_RST[i];
      end
    end else begin
      rf <= next_rf;
    end
  end

  // read data stands one cycle, zero for unmapped or idle
  always_comb begin
    next_rdata = BYTE_ZERO;
    if (rd) begin
      for (int i = 0; i < NREG; i++) begin
        if (addr == REG_ADDR[i]) begin
          next_rdata = rf[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // everything derived from the next state or the step into it, so outputs are registered
  always_comb begin
    in_rst_next = (next_state == ST_HOLD);
    next_vec_rd = (next_state == ST_VEC_LO) || (next_state == ST_VEC_HI);
    next_vec_addr = (next_state == ST_VEC_HI) ? VEC_HI_ADDR : VEC_LO_ADDR;
    next_pc = pc;
    next_pc_load = 1'b0;
    if (state == ST_LOAD && next_state == ST_RUN) begin
      next_pc = {vec_data, pc_lo};
      next_pc_load = 1'b1;
    end
    // cpu clock only once the vector is in
    next_cpu_clk_en = (next_state == ST_RUN);
    // internal high-speed clock runs from release on
    next_hs_osc_en = !in_rst_next;
    // crystals and external clocks off in reset, software-enabled after
    next_main_osc_en = !in_rst_next && next_rf[IX_CLKCTL][CLK_MAIN_BIT];
    next_sub_osc_en = !in_rst_next && next_rf[IX_CLKCTL][CLK_SUB_BIT];
    next_ext_main_clk_en = !in_rst_next && next_rf[IX_CLKCTL][CLK_EXTM_BIT];
    next_ext_sub_clk_en = !in_rst_next && next_rf[IX_CLKCTL][CLK_EXTS_BIT];
    next_clk_pin_port_mode = in_rst_next;
    // ports float through reset and the settle wait
    next_port_hiz = in_rst_next || (next_state == ST_SETTLE);
    // indicator low in reset, then follows its latch
    next_reset_ind_o = !in_rst_next && next_rf[IX_PORTIND][PORTIND_LVL_BIT];
    next_periph_rst = in_rst_next;
    next_wdt_rst = in_rst_next;
    next_lvd_rst = in_rst_next && !lvi_only;
    // standby at entry decides whether ram keeps its content
    next_ram_retain = ram_retain;
    if (state == ST_RUN && src_any) begin
      next_ram_retain = standby;
    end
  end

  // output registers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdata <= BYTE_ZERO;
      vec_addr <= VEC_LO_ADDR;
      vec_rd <= 1'b0;
      pc <= 16'h0000;
      pc_load <= 1'b0;
      cpu_clk_en <= 1'b0;
      hs_osc_en <= 1'b0;
      main_osc_en <= 1'b0;
      sub_osc_en <= 1'b0;
      ext_main_clk_en <= 1'b0;
      ext_sub_clk_en <= 1'b0;
      clk_pin_port_mode <= 1'b1;
      port_hiz <= 1'b1;
      reset_ind_o <= 1'b0;
      reset_ind_oe <= 1'b1;
      periph_rst <= 1'b1;
      wdt_rst <= 1'b1;
      lvd_rst <= 1'b1;
      ram_retain <= 1'b0;
    end else begin
      rdata <= next_rdata;
      vec_addr <= next_vec_addr;
      vec_rd <= next_vec_rd;
      pc <= next_pc;
      pc_load <= next_pc_load;
      cpu_clk_en <= next_cpu_clk_en;
      hs_osc_en <= next_hs_osc_en;
      main_osc_en <= next_main_osc_en;
      sub_osc_en <= next_sub_osc_en;
      ext_main_clk_en <= next_ext_main_clk_en;
      ext_sub_clk_en <= next_ext_sub_clk_en;
      clk_pin_port_mode <= next_clk_pin_port_mode;
      port_hiz <= next_port_hiz;
      reset_ind_o <= next_reset_ind_o;
      reset_ind_oe <= 1'b1; // indicator pin is output-only
      periph_rst <= next_periph_rst;
      wdt_rst <= next_wdt_rst;
      lvd_rst <= next_lvd_rst;
      ram_retain <= next_ram_retain;
    end
  end

endmodule : rcf_reset_ctrl

`default_nettype wire

// File: design/rcf_pad_unused.sv
`timescale 1ns/10ps
`default_nettype none
// no further logic
`default_nettype wire

// File: verif/rcf_reset_ctrl_sva.sv
`timescale 1ns/10ps
`default_nettype none
module rcf_reset_ctrl_sva (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic wdt_ovf,
  input wire logic lvi_det,
  input wire logic [rcf_pkg::RCF_AW-1:0] addr,
  input wire logic rd,
  input wire logic [rcf_pkg::RCF_DW-1:0] rdata,
  input wire logic [15:0] vec_addr,
  input wire logic vec_rd,
  input wire logic [7:0] vec_data,
  input wire logic [15:0] pc,
  input wire logic pc_load,
  input wire logic cpu_clk_en,
  input wire logic hs_osc_en,
  input wire logic main_osc_en,
  input wire logic sub_osc_en,
  input wire logic ext_main_clk_en,
  input wire logic ext_sub_clk_en,
  input wire logic clk_pin_port_mode,
  input wire logic port_hiz,
  input wire logic reset_ind_o,
  input wire logic reset_ind_oe,
  input wire logic periph_rst,
  input wire logic wdt_rst,
  input wire logic ext_rst_n,
  input wire logic poc_det,
  input wire logic lvd_rst
);
  import rcf_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // whole-byte read of the cause register while running
  sequence cause_rd;
    rd && addr == REG_ADDR[IX_CAUSE] && cpu_clk_en;
  endsequence
  // two vector bytes, low address first
  sequence vec_fetch;
    vec_rd && vec_addr == VEC_LO_ADDR ##1 vec_rd && vec_addr == VEC_HI_ADDR ##1 !vec_rd;
  endsequence
  a_ind_low: assert property (periph_rst |-> !reset_ind_o && reset_ind_oe && port_hiz)
    else $error("indicator pin not driven low in reset");
  a_clk_gated: assert property (periph_rst |-> !cpu_clk_en && !hs_osc_en && !pc_load)
    else $error("clocks running in reset");
  a_xtal_stop: assert property (periph_rst |-> !(main_osc_en | sub_osc_en | ext_main_clk_en | ext_sub_clk_en)
    && clk_pin_port_mode)
    else $error("crystal or external clock active in reset");
  a_wdt_self: assert property ($rose(wdt_ovf) && cpu_clk_en |-> ##[2:3] (wdt_rst && periph_rst))
    else $error("watchdog overflow did not reset");
  a_lvi_enter: assert property ($rose(lvi_det) && cpu_clk_en |-> ##[2:3] (periph_rst && !reset_ind_o))
    else $error("low voltage did not reset");
  a_vec_order: assert property (vec_rd && vec_addr == VEC_LO_ADDR |-> vec_fetch ##1 (pc_load && cpu_clk_en))
    else $error("vector fetch order wrong");
  a_pc_value: assert property (pc_load |-> pc == {$past(vec_data, 1), $past(vec_data, 2)})
    else $error("pc not loaded from vector");
  a_cause_bits: assert property (rd && addr == REG_ADDR[IX_CAUSE] |=> rdata[7:5] == 3'h0 && rdata[3:1] == 3'h0)
    else $error("cause register spare bits set");
  a_read_clear: assert property (cause_rd ##1 (!rd && cpu_clk_en)[*2] ##1 cause_rd |=> rdata == 8'h00)
    else $error("cause register not cleared by read");
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside read cycle");
  a_run_clean: assert property (cpu_clk_en |-> hs_osc_en && !port_hiz && !periph_rst)
    else $error("running without high-speed clock");
  a_lvd_keep: assert property (lvi_det && !wdt_ovf && ext_rst_n && !poc_det && !lvd_rst |=> !lvd_rst)
    else $error("low-voltage detector reset by its own reset");
endmodule : rcf_reset_ctrl_sva
bind rcf_reset_ctrl rcf_reset_ctrl_sva i_rcf_reset_ctrl_sva (.clk_sys(clk_sys), .nrst(nrst), .wdt_ovf(wdt_ovf),
  .lvi_det(lvi_det), .addr(addr), .rd(rd), .rdata(rdata), .vec_addr(vec_addr), .vec_rd(vec_rd),
  .vec_data(vec_data), .pc(pc), .pc_load(pc_load), .cpu_clk_en(cpu_clk_en), .hs_osc_en(hs_osc_en),
  .main_osc_en(main_osc_en), .sub_osc_en(sub_osc_en), .ext_main_clk_en(ext_main_clk_en),
  .ext_sub_clk_en(ext_sub_clk_en), .clk_pin_port_mode(clk_pin_port_mode), .port_hiz(port_hiz),
  .reset_ind_o(reset_ind_o), .reset_ind_oe(reset_ind_oe), .periph_rst(periph_rst), .wdt_rst(wdt_rst),
  .ext_rst_n(ext_rst_n), .poc_det(poc_det), .lvd_rst(lvd_rst));
`default_nettype wire

// File: verif/rcf_vec_mem.sv
`timescale 1ns/10ps
`default_nettype none
module rcf_vec_mem (
  input wire logic clk_sys,
  input wire logic [15:0] vec_addr,
  input wire logic vec_rd,
  input wire logic [7:0] vec_lo,
  input wire logic [7:0] vec_hi,
  output logic [7:0] vec_data
);
  import rcf_pkg::*;
  initial vec_data = 8'hA5;
  // answer one cycle after a fetch, else a pattern that changes every cycle
  always @(posedge clk_sys) begin
    if (vec_rd) begin
      vec_data <= (vec_addr == VEC_HI_ADDR) ? vec_hi : vec_lo;
    end else begin
      vec_data <= ~vec_data;
    end
  end
endmodule : rcf_vec_mem
`default_nettype wire

// File: verif/reset_control_and_cause_flags_test.sv
`timescale 1ns/10ps
`default_nettype none
module reset_control_and_cause_flags_test;
  import rcf_pkg::*;
  localparam int PIN_MIN = 1250; // 10 us at 8 ns
  logic clk_sys, nrst, ext_rst_n, poc_det, lvi_det, wdt_ovf, standby, opt_wdt_alt, wr, rd, sb;
  logic vec_rd, pc_load, cpu_clk_en, hs_osc_en, main_osc_en, sub_osc_en, ext_main_clk_en, ext_sub_clk_en;
  logic clk_pin_port_mode, port_hiz, reset_ind_o, reset_ind_oe, periph_rst, wdt_rst, lvd_rst, ram_retain;
  logic [RCF_AW-1:0] addr;
  logic [RCF_DW-1:0] wdata;
  logic [RCF_DW-1:0] rdata;
  logic [15:0] vec_addr;
  logic [15:0] pc;
  logic [7:0] vec_data, vec_lo, vec_hi;
  logic [7:0] exp_reg [NREG];
  logic [3:0] src_tab [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hC};
  integer seed = 32'h30e1d350;
  int errors = 0;
  int num_checks = 0;
  ////////////////////////////////////////////////////////////////
  rcf_reset_ctrl #(.HOLD_MIN(4), .SETTLE_UNIT(1)) i_rcf_reset_ctrl (.clk_sys(clk_sys), .nrst(nrst),
    .ext_rst_n(ext_rst_n), .poc_det(poc_det), .lvi_det(lvi_det), .wdt_ovf(wdt_ovf), .standby(standby),
    .opt_wdt_alt(opt_wdt_alt), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .vec_addr(vec_addr), .vec_rd(vec_rd), .vec_data(vec_data), .pc(pc), .pc_load(pc_load),
    .cpu_clk_en(cpu_clk_en), .hs_osc_en(hs_osc_en), .main_osc_en(main_osc_en), .sub_osc_en(sub_osc_en),
    .ext_main_clk_en(ext_main_clk_en), .ext_sub_clk_en(ext_sub_clk_en), .clk_pin_port_mode(clk_pin_port_mode),
    .port_hiz(port_hiz), .reset_ind_o(reset_ind_o), .reset_ind_oe(reset_ind_oe), .periph_rst(periph_rst),
    .wdt_rst(wdt_rst), .lvd_rst(lvd_rst), .ram_retain(ram_retain));
  rcf_vec_mem i_rcf_vec_mem (.clk_sys(clk_sys), .vec_addr(vec_addr), .vec_rd(vec_rd), .vec_lo(vec_lo),
    .vec_hi(vec_hi), .vec_data(vec_data));
  // 125 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask : bus_wr
  task automatic bus_rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    @(posedge clk_sys);
    d = rdata;
  endtask : bus_rd
  // reference model of the register file after a reset episode
  task automatic model_reset(input logic [3:0] s);
    logic [7:0] c;
    c = exp_reg[IX_CAUSE];
    if (s[0] || s[1]) c = 8'h00;
    if (s[2]) c[CAUSE_WDT_BIT] = 1'b1;
    if (s[3]) c[CAUSE_LV_BIT] = 1'b1;
    for (int i = 0; i < NREG; i++) begin
      if (!(s == 4'h8 && REG_LVH[i])) exp_reg[i] = REG_RST[i];
    end
    exp_reg[IX_CAUSE] = c;
    exp_reg[IX_WDTEN] = opt_wdt_alt ? WATCHDOG_ENABLE_REGISTER_RST_ALT : REG_RST[IX_WDTEN];
    exp_reg[IX_OSSTAT] = OSSTAT_DONE;
  endtask : model_reset
  task automatic wait_run();
    int n;
    n = 0;
    while (pc_load !== 1'b1 && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    check(16'(pc_load), 16'h0001);
    check(pc, {vec_hi, vec_lo});
  endtask : wait_run
  task automatic check_all();
    logic [7:0] d;
    for (int i = 0; i < NREG; i++) begin
      bus_rd(REG_ADDR[i], d);
      check(16'(d), 16'(exp_reg[i]));
      if (i == IX_CAUSE) begin
        // cause register only ever read as a whole byte
        bus_rd(REG_ADDR[i], d);
        check(16'(d), 16'h0000);
        exp_reg[i] = 8'h00;
      end
    end
    bus_rd(16'hFF00, d);
    check(16'(d), 16'h0000);
  endtask : check_all
  // random writes everywhere; read-only places must ignore them
  task automatic write_all();
    logic [7:0] d;
    for (int i = 0; i < NREG; i++) begin
      d = 8'($random(seed));
      bus_wr(REG_ADDR[i], d);
      if (!REG_RO[i]) exp_reg[i] = d & REG_MASK[i];
    end
    bus_wr(REG_ADDR[IX_PORTIND], 8'h01);
    exp_reg[IX_PORTIND] = 8'h01;
    repeat (2) @(posedge clk_sys);
    check(16'(reset_ind_o), 16'h0001);
    check(16'({ext_sub_clk_en, ext_main_clk_en, sub_osc_en, main_osc_en}), 16'(exp_reg[IX_CLKCTL][3:0]));
  endtask : write_all
  task automatic episode(input logic [3:0] s);
    sb = 1'($random(seed));
    standby <= sb;
    vec_lo <= 8'($random(seed));
    vec_hi <= 8'($random(seed));
    @(posedge clk_sys);
    ext_rst_n <= !s[0];
    poc_det <= s[1];
    wdt_ovf <= s[2];
    lvi_det <= s[3];
    repeat (5) @(posedge clk_sys);
    check(16'({reset_ind_o, cpu_clk_en, port_hiz, clk_pin_port_mode}), 16'h0003);
    check(16'({lvd_rst, periph_rst, wdt_rst}), {13'h0000, s != 4'h8, 2'h3});
    repeat (PIN_MIN - 5) @(posedge clk_sys);
    ext_rst_n <= 1'b1;
    poc_det <= 1'b0;
    wdt_ovf <= 1'b0;
    lvi_det <= 1'b0;
    model_reset(s);
    wait_run();
    check(16'(ram_retain), 16'(sb));
  endtask : episode
  task automatic results();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////
  // main sequence: two power-on boots, each followed by every reset source
  initial begin
    nrst = 1'b0;
    ext_rst_n = 1'b1;
    {poc_det, lvi_det, wdt_ovf, standby, opt_wdt_alt, wr, rd, sb} = 8'h00;
    addr = '0;
    wdata = '0;
    vec_lo = 8'h34;
    vec_hi = 8'h12;
    for (int b = 0; b < 2; b++) begin
      nrst <= 1'b0;
      opt_wdt_alt <= 1'(b);
      repeat (4) @(posedge clk_sys);
      nrst <= 1'b1;
      model_reset(4'h2);
      wait_run();
      check_all();
      $display("test boot %0d done", b);
      for (int k = 0; k < 5; k++) begin
        write_all();
        check_all();
        episode(src_tab[k]);
        check_all();
        $display("test source %0d done", k);
      end
    end
    results();
  end
  // watchdog against a hang
  initial begin
    #400000;
    errors++;
    results();
  end
endmodule : reset_control_and_cause_flags_test
`default_nettype wire
